// *** rtl/pdil_pkg.sv ***
// shared constants and types of the program and debug instruction layer
package pdil_pkg;

  // ----------------------------------------------------------------------
  // instruction byte layout
  // ----------------------------------------------------------------------
  localparam int OPC_LSB = 5;
  localparam int MODE_LSB = 2;
  localparam int SIZEB_LSB = 0;
  localparam int KEY_SIB_BIT = 2;
  localparam logic [2:0] OP_DIRECT_LOAD = 3'h0;
  localparam logic [2:0] OP_INDIRECT_LOAD = 3'h1;
  localparam logic [2:0] OP_DIRECT_STORE = 3'h2;
  localparam logic [2:0] OP_INDIRECT_STORE = 3'h3;
  localparam logic [2:0] OP_CTRL_LOAD = 3'h4;
  localparam logic [2:0] OP_REPEAT = 3'h5;
  localparam logic [2:0] OP_CTRL_STORE = 3'h6;
  localparam logic [2:0] OP_KEY = 3'h7;

  // pointer_mode_field codes
  localparam logic [1:0] PTR_AT = 2'h0;
  localparam logic [1:0] PTR_INC = 2'h1;
  localparam logic [1:0] PTR_REG = 2'h2;

  // key size codes and frame counts
  localparam logic [1:0] KEY_SIZE_64 = 2'h0;
  localparam logic [4:0] KEY_BYTES = 5'h08;
  localparam logic [4:0] SIB_SHORT_BYTES = 5'h08;
  localparam logic [4:0] SIB_LONG_BYTES = 5'h10;

  localparam logic [7:0] ACK_CHAR = 8'h40;

  // ----------------------------------------------------------------------
  // control space map, fields and reset values
  // ----------------------------------------------------------------------
  localparam logic [3:0] CS_STATUS_A = 4'h0;
  localparam logic [3:0] CS_STATUS_B = 4'h1;
  localparam logic [3:0] CS_CTRL_A = 4'h2;
  localparam logic [3:0] CS_CTRL_B = 4'h3;
  localparam int INTERBYTE_DELAY_ENABLE_BIT = 7;
  localparam logic [2:0] GUARD_RST = 3'h0;
  localparam logic INTERBYTE_DELAY_ENABLE_RST = 1'b0;

  // idle bit counts
  localparam logic [3:0] GUARD_MIN_BITS = 4'h2;
  localparam logic [3:0] IDLE_NORMAL_BITS = 4'h2;
  localparam logic [3:0] IDLE_EXTRA_BITS = 4'h2;

  // error_signature_field codes
  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_LINK = 3'h1;
  localparam logic [2:0] ERR_BUS = 3'h2;
  localparam logic [2:0] ERR_INSTR = 3'h3;

  typedef enum logic [2:0] {
    S_SYNC = 3'h0,
    S_INSTR = 3'h1,
    S_ADDR = 3'h2,
    S_DATA = 3'h3,
    S_BUS = 3'h4,
    S_TX = 3'h5,
    S_ERR = 3'h6
  } pdil_state_t;

endpackage : pdil_pkg

// *** rtl/pdil_gap_timer.sv ***
// idle bit counter that paces each transmitted byte
`timescale 1ns/1ps
`default_nettype none
module pdil_gap_timer #(
  parameter int CNT_W = 4
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [CNT_W-1:0] bits,
  input wire logic bitTick,
  output logic done
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  generate
    if (CNT_W < 2) begin : gBadWidth
      $error("gap counter too narrow");
    end
  endgenerate

  // load on start, then one step per bit period
  always_comb begin
    cnt_nxt = cnt_r;
    if (start) begin
      cnt_nxt = bits;
    end else if (bitTick && (cnt_r != '0)) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // count only: a start term here would loop back through the caller's ready path
  assign done = (cnt_r == '0);

endmodule : pdil_gap_timer
`default_nettype wire

// *** rtl/pdil_core.sv ***
// instruction layer of the single-wire program and debug port
// What this block does
// - indirect load data starts only after guard time; pointer loads alike
// - store with pointer mode 0x2 takes Size B pointer bytes, then acknowledges
// - mode 0x0 keeps pointer; mode 0x1 advances it by Size B after write
// - store data acknowledge sent only after a successful bus write
// - address and data operands up to 32 bits, chosen by size fields
// - control load takes its address from instruction bits 3:0, own registers only, one byte
// - control load byte follows the guard time after direction change
// - control store byte follows instruction at once, no response
// - repeat loads counter; next instruction runs counter plus one times
// - all but repeat repeatable; later iterations carry operands only
// - only a break aborts a running repeat
// - repeated indirect load streams blocks; guard only before first
// - without post-increment every iteration hits the same address
// - key takes only 64 bits; info block at most 128 bits
// - key gets no response; info block obeys current guard setting
// - two idle bits between bytes, two more with interbyte delay
// - interbyte delay never adds to the guard before first byte
// - info block readable any time outside the error state, sent as ASCII characters
// - each sync character raises a timer capture event
// - guard idle bits precede first reply byte after receiving
// - any link error blocks all requests until a break
`timescale 1ns/1ps
`default_nettype none
module pdil_core #(
  // ASCII text of the information block; value is arbitrary
  parameter logic [127:0] SIB_TEXT = "PDILFAM0NVM1OCD1",
  // status byte revision; value is arbitrary
  parameter logic [7:0] VERSION = 8'h10
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxSync,
  input wire logic rxBreak,
  input wire logic rxError,
  input wire logic bitTick,
  output logic txValid,
  output logic [7:0] txData,
  input wire logic txReady,
  output logic busReq,
  output logic busWrite,
  output logic [31:0] busAddr,
  output logic [31:0] busWdata,
  output logic [1:0] busSize,
  input wire logic busDone,
  input wire logic busOk,
  input wire logic [31:0] busRdata,
  output logic syncEvent,
  output logic keyValid,
  output logic [63:0] keyData,
  output logic [2:0] guardIntervalSetting,
  output logic interbyteDelayEnable,
  output logic [2:0] errorSignature,
  output logic repeatActive
);
  import pdil_pkg::*;

  // ----------------------------------------------------------------------
  // state and decode
  // ----------------------------------------------------------------------
  pdil_state_t state_r, state_nxt;
  logic [7:0] instr_r, instr_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic [31:0] ptr_r, ptr_nxt;
  logic [31:0] data_r, data_nxt;
  logic [63:0] key_r, key_nxt;
  logic [31:0] busAddr_r, busAddr_nxt;
  logic [4:0] idx_r, idx_nxt;
  logic [7:0] repeat_r, repeat_nxt;
  logic sendAck_r, sendAck_nxt;
  logic ackPhase_r, ackPhase_nxt;
  logic firstTx_r, firstTx_nxt;
  logic [2:0] guard_r, guard_nxt;
  logic interbyte_delay_enable_r, interbyte_delay_enable_nxt;
  logic [2:0] errSig_r, errSig_nxt;
  logic syncEvent_r, keyValid_r, keyValid_nxt;
  logic [7:0] txData_r, txByte, csRead;
  logic [2:0] opc;
  logic [1:0] mode;
  logic [3:0] csAddr;
  logic [4:0] aBytes, bBytes, rxCount, txCount;
  logic [31:0] addrIn, dataIn;
  logic [6:0] sibPos;
  logic [3:0] guardBits, interBits, gapBits;
  logic txFire, lastTx, rxLast, done, gapStart, gapDone, isStore, isDirect;

  assign opc = instr_r[OPC_LSB +: 3];
  assign mode = instr_r[MODE_LSB +: 2];
  assign csAddr = instr_r[3:0];
  // mode bits size the address only for direct ops; indirect ones use the low size field
  assign aBytes = isDirect ? ({3'h0, mode} + 5'h01) : bBytes;
  assign bBytes = {3'h0, instr_r[SIZEB_LSB +: 2]} + 5'h01;
  assign isStore = (opc == OP_DIRECT_STORE) || (opc == OP_INDIRECT_STORE);
  assign isDirect = (opc == OP_DIRECT_LOAD) || (opc == OP_DIRECT_STORE);
  assign sibPos = 7'h7F - {idx_r[3:0], 3'h0};
  assign guardBits = {1'b0, guard_r} + GUARD_MIN_BITS;
  assign interBits = interbyte_delay_enable_r ? IDLE_NORMAL_BITS + IDLE_EXTRA_BITS : IDLE_NORMAL_BITS;

  // first state of each iteration; later iterations skip sync and opcode
  function automatic pdil_state_t iterStart(input logic [7:0] ins);
    logic [2:0] op;
    logic [1:0] md;
    op = ins[OPC_LSB +: 3];
    md = ins[MODE_LSB +: 2];
    case (op)
      OP_DIRECT_LOAD: iterStart = S_ADDR;
      OP_DIRECT_STORE: iterStart = S_ADDR;
      OP_INDIRECT_STORE: iterStart = (md == PTR_REG) ? S_ADDR : S_DATA;
      OP_INDIRECT_LOAD: iterStart = (md == PTR_REG) ? S_TX : S_BUS;
      OP_CTRL_LOAD: iterStart = S_TX;
      OP_KEY: iterStart = ins[KEY_SIB_BIT] ? S_TX : S_DATA;
      default: iterStart = S_DATA;
    endcase
  endfunction : iterStart

  // ----------------------------------------------------------------------
  // byte counts, operand assembly and transmit byte choice
  // ----------------------------------------------------------------------
  always_comb begin
    rxCount = bBytes;
    if (state_r == S_ADDR) begin
      rxCount = aBytes;
    end else if (opc == OP_KEY) begin
      rxCount = KEY_BYTES;
    end else if ((opc == OP_REPEAT) || (opc == OP_CTRL_STORE)) begin
      rxCount = 5'h01;
    end
    txCount = bBytes;
    if (sendAck_r || (opc == OP_CTRL_LOAD)) begin
      txCount = 5'h01;
    end else if (opc == OP_KEY) begin
      txCount = (instr_r[1:0] == KEY_SIZE_64) ? SIB_SHORT_BYTES : SIB_LONG_BYTES;
    end else if ((opc == OP_INDIRECT_LOAD) && (mode == PTR_REG)) begin
      txCount = aBytes;
    end
    addrIn = (idx_r == 5'h00) ? 32'h0 : addr_r;
    addrIn[{idx_r[1:0], 3'h0} +: 8] = rxData;
    dataIn = (idx_r == 5'h00) ? 32'h0 : data_r;
    dataIn[{idx_r[1:0], 3'h0} +: 8] = rxData;
    // only this block's own registers answer a control load
    case (csAddr)
      CS_STATUS_A: csRead = VERSION;
      CS_STATUS_B: csRead = {5'h00, errSig_r};
      CS_CTRL_A: csRead = {5'h00, guard_r};
      CS_CTRL_B: csRead = {interbyte_delay_enable_r, 7'h00};
      default: csRead = 8'h00;
    endcase
    if (sendAck_r) begin
      txByte = ACK_CHAR;
    end else if (opc == OP_CTRL_LOAD) begin
      txByte = csRead;
    end else if (opc == OP_KEY) begin
      txByte = SIB_TEXT[sibPos -: 8];
    end else if ((opc == OP_INDIRECT_LOAD) && (mode == PTR_REG)) begin
      txByte = ptr_r[{idx_r[1:0], 3'h0} +: 8];
    end else begin
      txByte = data_r[{idx_r[1:0], 3'h0} +: 8];
    end
  end

  assign txFire = txValid && txReady;
  assign lastTx = (idx_r == txCount - 5'h01);
  assign rxLast = (idx_r == rxCount - 5'h01);

  // ----------------------------------------------------------------------
  // instruction sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    instr_nxt = instr_r;
    addr_nxt = addr_r;
    ptr_nxt = ptr_r;
    data_nxt = data_r;
    key_nxt = key_r;
    idx_nxt = idx_r;
    repeat_nxt = repeat_r;
    sendAck_nxt = sendAck_r;
    ackPhase_nxt = ackPhase_r;
    firstTx_nxt = firstTx_r;
    guard_nxt = guard_r;
    interbyte_delay_enable_nxt = interbyte_delay_enable_r;
    errSig_nxt = errSig_r;
    keyValid_nxt = 1'b0;
    busAddr_nxt = busAddr_r;
    done = 1'b0;
    case (state_r)
      S_SYNC: begin
        if (rxSync) begin
          state_nxt = S_INSTR;
        end
      end
      S_INSTR: begin
        if (rxValid) begin
          instr_nxt = rxData;
          idx_nxt = 5'h00;
          sendAck_nxt = 1'b0;
          ackPhase_nxt = 1'b0;
          if ((rxData[OPC_LSB +: 3] == OP_KEY) && !rxData[KEY_SIB_BIT]
              && (rxData[1:0] != KEY_SIZE_64)) begin
            state_nxt = S_ERR;
            errSig_nxt = ERR_INSTR;
          end else begin
            state_nxt = iterStart(rxData);
          end
        end
      end
      S_ADDR: begin
        if (rxValid) begin
          addr_nxt = addrIn;
          idx_nxt = idx_r + 5'h01;
          if (rxLast) begin
            idx_nxt = 5'h00;
            if (opc == OP_DIRECT_LOAD) begin
              state_nxt = S_BUS;
            end else begin
              if (opc == OP_INDIRECT_STORE) begin
                ptr_nxt = addrIn;
              end
              sendAck_nxt = 1'b1;
              state_nxt = S_TX;
            end
          end
        end
      end
      S_DATA: begin
        if (rxValid) begin
          data_nxt = dataIn;
          key_nxt[{idx_r[2:0], 3'h0} +: 8] = rxData;
          idx_nxt = idx_r + 5'h01;
          if (rxLast) begin
            idx_nxt = 5'h00;
            case (opc)
              OP_CTRL_STORE: begin
                // only byte bits 2:0 (guard) or bit 7 (interbyte delay) land in the register, nothing is sent back
                if (csAddr == CS_CTRL_A) begin
                  guard_nxt = rxData[2:0];
                end
                if (csAddr == CS_CTRL_B) begin
                  interbyte_delay_enable_nxt = rxData[INTERBYTE_DELAY_ENABLE_BIT];
                end
                done = 1'b1;
              end
              OP_REPEAT: begin
                repeat_nxt = rxData;
                state_nxt = S_SYNC;
              end
              OP_KEY: begin
                keyValid_nxt = 1'b1;
                done = 1'b1;
              end
              default: state_nxt = S_BUS;
            endcase
          end
        end
      end
      S_BUS: begin
        if (busDone) begin
          if (!busOk) begin
            state_nxt = S_ERR;
            errSig_nxt = ERR_BUS;
          end else begin
            if (!isDirect && (mode == PTR_INC)) begin
              ptr_nxt = ptr_r + {27'h0, bBytes};
            end
            if (!isStore) begin
              data_nxt = busRdata;
            end
            sendAck_nxt = isStore;
            idx_nxt = 5'h00;
            state_nxt = S_TX;
          end
        end
      end
      S_TX: begin
        if (txFire) begin
          idx_nxt = idx_r + 5'h01;
          if (lastTx) begin
            idx_nxt = 5'h00;
            sendAck_nxt = 1'b0;
            if (sendAck_r && (opc == OP_DIRECT_STORE) && !ackPhase_r) begin
              ackPhase_nxt = 1'b1;
              state_nxt = S_DATA;
            end else begin
              done = 1'b1;
            end
          end
        end
      end
      S_ERR: state_nxt = S_ERR;
      default: state_nxt = S_SYNC;
    endcase
    // end of one iteration: run again from the operands or wait for sync
    if (done) begin
      ackPhase_nxt = 1'b0;
      if (repeat_r != 8'h00) begin
        repeat_nxt = repeat_r - 8'h01;
        state_nxt = iterStart(instr_r);
      end else begin
        state_nxt = S_SYNC;
      end
    end
    if (txFire) begin
      firstTx_nxt = 1'b0;
    end
    if (rxValid) begin
      firstTx_nxt = 1'b1;
    end
    if (rxError && (state_r != S_ERR)) begin
      state_nxt = S_ERR;
      errSig_nxt = ERR_LINK;
    end
    // break is the only way out of a repeat and out of the error state
    if (rxBreak) begin
      state_nxt = S_SYNC;
      repeat_nxt = 8'h00;
      sendAck_nxt = 1'b0;
      ackPhase_nxt = 1'b0;
    end
    // decode the incoming opcode: a load may go straight from S_INSTR to S_BUS
    if ((state_nxt == S_BUS) && (state_r != S_BUS)) begin
      busAddr_nxt = ((instr_nxt[OPC_LSB +: 3] == OP_DIRECT_LOAD)
          || (instr_nxt[OPC_LSB +: 3] == OP_DIRECT_STORE)) ? addr_nxt : ptr_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // guard and interbyte pacing
  // ----------------------------------------------------------------------
  assign gapStart = (state_nxt == S_TX) && ((state_r != S_TX) || txFire);
  // after receiving, only the guard applies; otherwise only interbyte bits
  assign gapBits = firstTx_nxt ? guardBits : interBits;

  pdil_gap_timer #(
    .CNT_W(4)
  ) uGap (
    .ref_clk(ref_clk),
    .reset(reset),
    .start(gapStart),
    .bits(gapBits),
    .bitTick(bitTick),
    .done(gapDone)
  );

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= S_SYNC;
      instr_r <= 8'h00;
      addr_r <= 32'h0;
      ptr_r <= 32'h0;
      data_r <= 32'h0;
      key_r <= 64'h0;
      busAddr_r <= 32'h0;
      idx_r <= 5'h00;
      repeat_r <= 8'h00;
      sendAck_r <= 1'b0;
      ackPhase_r <= 1'b0;
      firstTx_r <= 1'b0;
      guard_r <= GUARD_RST;
      interbyte_delay_enable_r <= INTERBYTE_DELAY_ENABLE_RST;
      errSig_r <= ERR_NONE;
      keyValid_r <= 1'b0;
      syncEvent_r <= 1'b0;
      txData_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      instr_r <= instr_nxt;
      addr_r <= addr_nxt;
      ptr_r <= ptr_nxt;
      data_r <= data_nxt;
      key_r <= key_nxt;
      busAddr_r <= busAddr_nxt;
      idx_r <= idx_nxt;
      repeat_r <= repeat_nxt;
      sendAck_r <= sendAck_nxt;
      ackPhase_r <= ackPhase_nxt;
      firstTx_r <= firstTx_nxt;
      guard_r <= guard_nxt;
      interbyte_delay_enable_r <= interbyte_delay_enable_nxt;
      errSig_r <= errSig_nxt;
      keyValid_r <= keyValid_nxt;
      syncEvent_r <= rxSync;
      txData_r <= txByte;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign txValid = (state_r == S_TX) && gapDone;
  assign txData = txData_r;
  assign busReq = (state_r == S_BUS);
  assign busWrite = isStore;
  assign busAddr = busAddr_r;
  assign busWdata = data_r;
  assign busSize = instr_r[SIZEB_LSB +: 2];
  assign syncEvent = syncEvent_r;
  assign keyValid = keyValid_r;
  assign keyData = key_r;
  assign guardIntervalSetting = guard_r;
  assign interbyteDelayEnable = interbyte_delay_enable_r;
  assign errorSignature = errSig_r;
  assign repeatActive = (repeat_r != 8'h00);

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  // bit periods seen since the current gap began
  logic [3:0] gapTicks_r;
  always_ff @(posedge ref_clk) begin
    if (reset || gapStart) begin
      gapTicks_r <= 4'h0;
    end else if (bitTick && (gapTicks_r != 4'hF)) begin
      gapTicks_r <= gapTicks_r + 4'h1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  guard_first_a: assert property ($rose(txValid) && firstTx_r |-> gapTicks_r == guardBits)
    else $error("first reply byte not preceded by guard bits");
  interbyte_gap_a: assert property ($rose(txValid) && !firstTx_r
      |-> gapTicks_r == (interbyte_delay_enable_r ? 4'h4 : 4'h2))
    else $error("wrong idle bit count between bytes");
  store_ack_a: assert property (busReq && busDone && busWrite && !rxBreak && !rxError
      |=> sendAck_r == $past(busOk))
    else $error("store acknowledge not tied to bus success");
  ptr_hold_a: assert property (busReq && busDone && busOk && opc == OP_INDIRECT_STORE
      && mode == PTR_AT |=> ptr_r == $past(ptr_r))
    else $error("pointer moved without post-increment");
  ptr_advance_a: assert property (busReq && busDone && busOk && !isDirect && mode == PTR_INC
      |=> ptr_r == $past(ptr_r) + {27'h0, $past(bBytes)})
    else $error("pointer not advanced by data size");
  repeat_count_a: assert property (done && repeat_r != 8'h00 && !rxBreak && !rxError
      |=> repeat_r == $past(repeat_r) - 8'h01 && state_r != S_SYNC)
    else $error("repeat iteration not counted");
  break_abort_a: assert property (rxBreak |=> state_r == S_SYNC && !repeatActive)
    else $error("break did not abort");
  error_hold_a: assert property (state_r == S_ERR && !rxBreak |=> state_r == S_ERR [*1]
      ##0 !busReq && !txValid)
    else $error("error state left without break");
  no_reply_a: assert property (state_r == S_DATA && rxValid && rxLast
      && (opc == OP_CTRL_STORE || opc == OP_KEY) |=> !sendAck_r ##1 state_r != S_TX
      || repeat_r != 8'h00)
    else $error("control store or key drew a response");
  sync_event_a: assert property (rxSync |=> syncEvent ##1 !syncEvent || $past(rxSync))
    else $error("sync event missing");

  repeat_load_c: cover property (repeatActive && state_r == S_BUS ##[1:200] !repeatActive);
  store_ack_c: cover property (sendAck_r && txFire);
  sib_out_c: cover property (opc == OP_KEY && txFire && lastTx);
  error_exit_c: cover property (state_r == S_ERR ##1 rxBreak);

endmodule : pdil_core
`default_nettype wire

// *** tb/pdil_bus_model.sv ***
// system bus responder standing behind the instruction layer
`timescale 1ns/1ps
`default_nettype none
module pdil_bus_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic busReq,
  input wire logic busWrite,
  input wire logic [31:0] busAddr,
  input wire logic [31:0] busWdata,
  input wire logic busFail,
  input wire logic slow,
  output logic busDone,
  output logic busOk,
  output logic [31:0] busRdata
);
  // ----------------------------------------------------------------------
  // byte memory with prompt or slow completion
  // ----------------------------------------------------------------------
  logic [7:0] mem [0:255];
  logic [2:0] waitCnt_r;

  // idle read data keeps toggling so a stale value never looks valid
  always_ff @(posedge ref_clk) begin
    busDone <= 1'b0;
    if (reset) begin
      waitCnt_r <= 3'h0;
      busOk <= 1'b0;
      busRdata <= 32'h0;
    end else if (busReq && !busDone) begin
      if (waitCnt_r == (slow ? 3'h5 : 3'h0)) begin
        busDone <= 1'b1;
        busOk <= !busFail;
        waitCnt_r <= 3'h0;
        busRdata <= {24'h0, mem[busAddr[7:0]]};
        if (busWrite && !busFail) mem[busAddr[7:0]] <= busWdata[7:0];
      end else waitCnt_r <= waitCnt_r + 3'h1;
    end else busRdata <= ~busRdata;
  end
endmodule : pdil_bus_model
`default_nettype wire

// *** tb/pdil_core_test.sv ***
// self-checking bench of the instruction layer
`timescale 1ns/1ps
`default_nettype none
module pdil_core_test;
  import pdil_pkg::*;
  logic ref_clk, reset, rxValid, rxSync, rxBreak, bitTick, txValid, busReq, busWrite;
  logic busDone, busOk, syncEvent, interbyteDelayEnable, busFail, slow, rxError, keyValid;
  logic repeatActive;
  logic [63:0] keyData;
  // info block text for this bench; value is arbitrary
  localparam logic [127:0] SIB_CHECK = "BENCHINFOBLOCK01";
  logic [7:0] rxData, txData;
  logic [31:0] busAddr, busWdata, busRdata;
  logic [2:0] guardIntervalSetting, errorSignature;
  logic [1:0] tickCnt, busSize;
  int n_fail, total_checks, waited;

  // link side tied ready: each reply byte stands one cycle
  pdil_core #(.SIB_TEXT(SIB_CHECK)) i_pdil_core (.ref_clk, .reset, .rxValid, .rxData,
    .rxSync, .rxBreak, .rxError, .bitTick, .txValid, .txData, .txReady(1'b1), .busReq,
    .busWrite, .busAddr, .busWdata, .busSize, .busDone, .busOk, .busRdata, .syncEvent,
    .keyValid, .keyData, .guardIntervalSetting, .interbyteDelayEnable,
    .errorSignature, .repeatActive);
  pdil_bus_model i_pdil_bus_model (.ref_clk, .reset, .busReq, .busWrite, .busAddr,
    .busWdata, .busFail, .slow, .busDone, .busOk, .busRdata);

  // ----------------------------------------------------------------------
  // clock, bit period of four cycles, watchdog
  // ----------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    tickCnt <= reset ? 2'h0 : tickCnt + 2'h1;
    bitTick <= !reset && (tickCnt == 2'h3);
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    stop_test();
  end

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (exp !== got) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task send(input logic [7:0] b);
    @(posedge ref_clk) rxValid <= 1'b1;
    rxData <= b;
    @(posedge ref_clk) rxValid <= 1'b0;
    rxData <= ~b;
  endtask : send
  task sync;
    @(posedge ref_clk) rxSync <= 1'b1;
    @(posedge ref_clk) rxSync <= 1'b0;
    #1 chk("syncEvent", 1, syncEvent);
  endtask : sync
  // gap measured in cycles guards against replies sent too early
  task get(input logic [7:0] exp, input int minWait);
    waited = 0;
    do begin
      @(posedge ref_clk);
      #1 waited++;
    end while (txValid !== 1'b1 && waited < 3000);
    chk("txData", exp, txData);
    chk("replyGap", 1, waited >= minWait);
  endtask : get
  task quiet;
    waited = 0;
    repeat (200) @(posedge ref_clk) #1 waited += (txValid === 1'b1);
    chk("quietLink", 0, waited);
  endtask : quiet
  task waitBus;
    waited = 0;
    do @(posedge ref_clk) #1 waited++; while (busReq !== 1'b1 && waited < 200);
    chk("busReq", 1, busReq);
  endtask : waitBus

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task t_ctrl;
    sync();
    send(8'hC2);
    send(8'h01);
    #250 chk("guard", 1, guardIntervalSetting);
    sync();
    send(8'h80);
    get(8'h10, 7);
  endtask : t_ctrl
  task t_store;
    sync();
    send(8'h68);
    send(8'h20);
    get(ACK_CHAR, 0);
    sync();
    send(8'h64);
    send(8'hA5);
    waitBus();
    chk("busAddr", 32'h20, busAddr);
    chk("busWdata", 8'hA5, busWdata[7:0]);
    chk("busWrite", 1, busWrite);
    chk("busSize", 0, busSize);
    get(ACK_CHAR, 0);
    @(posedge ref_clk) slow <= 1'b1;
    sync();
    send(8'h60);
    send(8'h5A);
    waitBus();
    chk("busAddr", 32'h21, busAddr);
    get(ACK_CHAR, 0);
    sync();
    send(8'hA0);
    send(8'h01);
    sync();
    send(8'h60);
    send(8'h33);
    get(ACK_CHAR, 0);
    send(8'h5A);
    waitBus();
    chk("busAddr", 32'h21, busAddr);
    get(ACK_CHAR, 0);
    sync();
    send(8'h40);
    send(8'h30);
    get(ACK_CHAR, 0);
    send(8'hC3);
    waitBus();
    chk("busAddr", 32'h30, busAddr);
    get(ACK_CHAR, 0);
    sync();
    send(8'h00);
    send(8'h30);
    get(8'hC3, 7);
  endtask : t_store
  task t_rpt;
    @(posedge ref_clk) slow <= 1'b0;
    sync();
    send(8'hC3);
    send(8'h80);
    #250 chk("interbyte_delay_enable", 1, interbyteDelayEnable);
    sync();
    send(8'h68);
    send(8'h20);
    get(ACK_CHAR, 0);
    sync();
    send(8'hA0);
    send(8'h01);
    #1 chk("repeatActive", 1, repeatActive);
    sync();
    send(8'h24);
    get(8'hA5, 7);
    get(8'h5A, 12);
    quiet();
  endtask : t_rpt
  task t_key;
    sync();
    send(8'hE0);
    for (int i = 0; i < 8; i++) send(8'hB0 + 8'(i));
    #1 chk("keyValid", 1, keyValid);
    chk("keyLow", 32'hB3B2B1B0, keyData[31:0]);
    chk("keyHigh", 32'hB7B6B5B4, keyData[63:32]);
    quiet();
    sync();
    send(8'hE4);
    for (int i = 0; i < 8; i++) get(SIB_CHECK[127 - 8 * i -: 8], 0);
  endtask : t_key
  task t_err;
    @(posedge ref_clk) busFail <= 1'b1;
    sync();
    send(8'h64);
    send(8'h77);
    quiet();
    chk("errSig", ERR_BUS, errorSignature);
    @(posedge ref_clk) busFail <= 1'b0;
    send(8'h81);
    quiet();
    @(posedge ref_clk) rxBreak <= 1'b1;
    @(posedge ref_clk) rxBreak <= 1'b0;
    sync();
    send(8'h81);
    get({5'h0, ERR_BUS}, 0);
    @(posedge ref_clk) rxError <= 1'b1;
    @(posedge ref_clk) rxError <= 1'b0;
    #1 chk("errSig", ERR_LINK, errorSignature);
  endtask : t_err

  task stop_test;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  // reset for four cycles, then the scenarios in turn
  initial begin
    reset = 1'b1;
    {rxValid, rxSync, rxBreak, rxError, busFail, slow} = 6'h00;
    rxData = 8'h00;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    t_ctrl();
    t_store();
    t_rpt();
    t_key();
    t_err();
    stop_test();
  end
endmodule : pdil_core_test
`default_nettype wire
